// ---- core/draft_damper_sequencer.sv ----
`timescale 1ns/100ps
// Contract
// - Selector open holds continuous open command
// - Auto: phases 0-2,80-83 open; 10,12 close
// - Phases 20-34 open; alarm 1 if unproven by 30
// - Phases 36-54 ignition; alarm 2 by 40
// - Phases 60,62 modulate with pulses to setpoint
// - Phases 70-78 open; alarm 3 by 74
// - Active alarm forces open until manual reset
// - Unlisted phases give no command and report idle status
// - Status distinguishes every command cause except alarm open, which reports drive-open like phase open
// - Rotation direction and setpoint polarity configurable
// - Manual force takes jog buttons while held
// - Global alarm clear also clears draft alarms
module draft_damper_sequencer
    import draft_pkg::*;
#(
    parameter int MOD_PERIOD = MOD_PERIOD_CYC,
    parameter int MOD_PULSE = MOD_PULSE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] burner_phase,
    input wire logic fuel_oil,
    input wire logic signed [15:0] draft_level,
    input wire logic open_proven,
    input wire logic closed_proven,
    input wire logic ign_proven,
    output logic damper_open,
    output logic damper_close,
    output logic damper_ign,
    output logic draft_alarm,
    output logic [1:0] alarm_code,
    output cmd_status_t cmd_status
);

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Draft and phase are multi-bit; both change slowly relative to pclk,
    // so a one-cycle skew between bits is tolerated.
    localparam int SYNC_W = 8 + 1 + 16 + 3;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [7:0] phase;
    logic oil_sel;
    logic signed [15:0] draft;
    logic open_pv;
    logic closed_pv;
    logic ign_pv;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {burner_phase, fuel_oil, draft_level, open_proven, closed_proven, ign_proven};
            sync2_reg <= sync1_reg;
        end
    end

    assign {phase, oil_sel, draft, open_pv, closed_pv, ign_pv} = sync2_reg;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    ctrl_t ctrl_reg;
    logic [31:0] setpt_reg;
    logic clear_req;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [31:0] status_word;
    damper_cmd_t cmd_reg;

    assign pready = 1'b1;
    assign addr_ok = (paddr == CTRL_OFS) || (paddr == SETPT_OFS) ||
                     (paddr == STATUS_OFS) || (paddr == CLEAR_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && !penable && !pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ctrl_t'(CTRL_RST[$bits(ctrl_t)-1:0]);
            setpt_reg <= SETPT_RST;
        end else if (wr_en) begin
            if (paddr == CTRL_OFS) begin
                ctrl_reg <= ctrl_t'(pwdata[$bits(ctrl_t)-1:0]);
            end
            if (paddr == SETPT_OFS) begin
                setpt_reg <= pwdata;
            end
        end
    end

    // Alarm clear is a write-one pulse; nothing inside clears it on its own
    assign clear_req = wr_en && (paddr == CLEAR_OFS) &&
                       (pwdata[CLEAR_DRAFT_BIT] || pwdata[CLEAR_GLOBAL_BIT]);

    always_comb begin
        status_word = '0;
        status_word[6:0] = cmd_status;
        status_word[ST_ALARM_CODE_LSB +: 2] = alarm_code;
        status_word[ST_ALARM_BIT] = draft_alarm;
        status_word[ST_PROOF_LSB +: 3] = {ign_pv, closed_pv, open_pv};
        status_word[ST_CMD_LSB +: 3] = cmd_reg;
        status_word[ST_PHASE_LSB +: 8] = phase;
    end

    // Read data is captured in the setup cycle so it stands through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_en) begin
            case (paddr)
                CTRL_OFS: prdata <= 32'(ctrl_reg);
                SETPT_OFS: prdata <= setpt_reg;
                STATUS_OFS: prdata <= status_word;
                default: prdata <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Proof tracking and draft alarms
    // ------------------------------------------------------------------
    logic in_purge;
    logic in_light;
    logic in_post;
    logic seen_purge_reg;
    logic seen_light_reg;
    logic seen_post_reg;
    logic purge_open_missed;
    logic light_off_position_missed;
    logic post_purge_open_missed;
    logic raise_any;
    logic [1:0] raise_code;

    assign in_purge = (phase >= PH_PURGE_LO) && (phase <= PH_PURGE_HI);
    assign in_light = (phase >= PH_IGN_LO) && (phase <= PH_IGN_HI);
    assign in_post = (phase >= PH_POST_LO) && (phase <= PH_POST_HI);

    // A proof seen anywhere in the window counts, even if it drops later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_purge_reg <= 1'b0;
            seen_light_reg <= 1'b0;
            seen_post_reg <= 1'b0;
        end else begin
            seen_purge_reg <= in_purge && (seen_purge_reg || open_pv);
            seen_light_reg <= in_light && (seen_light_reg || ign_pv);
            seen_post_reg <= in_post && (seen_post_reg || open_pv);
        end
    end

    assign purge_open_missed = in_purge && (phase >= PH_PURGE_DL) && !seen_purge_reg && !open_pv;
    assign light_off_position_missed = in_light && (phase >= PH_IGN_DL) &&
                                       !seen_light_reg && !ign_pv;
    assign post_purge_open_missed = in_post && (phase >= PH_POST_DL) && !seen_post_reg && !open_pv;
    assign raise_any = purge_open_missed || light_off_position_missed || post_purge_open_missed;
    assign raise_code = purge_open_missed ? ALM_PURGE :
                        light_off_position_missed ? ALM_LIGHT : ALM_POST;

    // Raise wins over a clear in the same cycle; the first code is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            draft_alarm <= 1'b0;
            alarm_code <= ALM_NONE;
        end else if (raise_any) begin
            draft_alarm <= 1'b1;
            if (!draft_alarm) begin
                alarm_code <= raise_code;
            end
        end else if (clear_req) begin
            draft_alarm <= 1'b0;
            alarm_code <= ALM_NONE;
        end
    end

    // ------------------------------------------------------------------
    // Modulation pulse generator
    // ------------------------------------------------------------------
    mod_state_t mod_reg;
    logic [31:0] mod_cnt_reg;
    logic modulating;
    logic signed [16:0] sp_sel;
    logic signed [17:0] err;
    logic signed [17:0] err_pol;
    logic want_raise;
    logic want_lower;
    logic pulse_open;
    logic pulse_close;

    assign sp_sel = oil_sel ? 17'(signed'(setpt_reg[31:16])) : 17'(signed'(setpt_reg[15:0]));
    assign err = 18'(draft) - 18'(sp_sel);
    assign err_pol = ctrl_reg.sp_negative ? -err : err;
    assign want_raise = err_pol > $signed({10'h000, ctrl_reg.deadband});
    assign want_lower = err_pol < -$signed({10'h000, ctrl_reg.deadband});

    // Each period is one decision: one pulse or none, then a quiet rest
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_reg <= MOD_WAIT;
            mod_cnt_reg <= '0;
        end else if (!modulating) begin
            mod_reg <= MOD_WAIT;
            mod_cnt_reg <= '0;
        end else begin
            mod_cnt_reg <= (mod_cnt_reg == 32'(MOD_PERIOD - 1)) ? '0 : mod_cnt_reg + 32'h1;
            case (mod_reg)
                MOD_WAIT: begin
                    if (mod_cnt_reg == '0 && want_raise) begin
                        mod_reg <= MOD_RAISE;
                    end else if (mod_cnt_reg == '0 && want_lower) begin
                        mod_reg <= MOD_LOWER;
                    end
                end
                MOD_RAISE, MOD_LOWER: begin
                    // The decision lands at count 1, so ending at MOD_PULSE gives a full-length pulse
                    if (mod_cnt_reg == 32'(MOD_PULSE)) begin
                        mod_reg <= MOD_WAIT;
                    end
                end
                default: mod_reg <= MOD_WAIT;
            endcase
        end
    end

    // Counter-clockwise mounting swaps which drive output opens the damper
    assign pulse_open = ctrl_reg.rot_ccw ? (mod_reg == MOD_LOWER) : (mod_reg == MOD_RAISE);
    assign pulse_close = ctrl_reg.rot_ccw ? (mod_reg == MOD_RAISE) : (mod_reg == MOD_LOWER);

    // ------------------------------------------------------------------
    // Command selection
    // ------------------------------------------------------------------
    damper_cmd_t cmd_next;
    cmd_status_t status_next;

    assign modulating = !ctrl_reg.selector_open && !draft_alarm && !raise_any && !ctrl_reg.manual_force &&
                        ((phase == PH_RUN_A) || (phase == PH_RUN_B));

    always_comb begin
        cmd_next = '0;
        status_next = ST_IDLE;
        if (ctrl_reg.selector_open) begin
            cmd_next.open = 1'b1;
            status_next = ST_SWITCH_OPEN;
        end else if (draft_alarm || raise_any) begin
            cmd_next.open = 1'b1;
            status_next = ST_DRIVE_OPEN;
        end else if (ctrl_reg.manual_force) begin
            cmd_next.open = ctrl_reg.jog_open && !ctrl_reg.jog_close;
            cmd_next.close = ctrl_reg.jog_close && !ctrl_reg.jog_open;
            status_next = ST_MANUAL;
        end else if (phase <= PH_LOCK_HI || (phase >= PH_VPT_LO && phase <= PH_VPT_HI) ||
                     in_purge || in_post) begin
            cmd_next.open = 1'b1;
            status_next = ST_DRIVE_OPEN;
        end else if (phase == PH_STBY_A || phase == PH_STBY_B) begin
            cmd_next.close = 1'b1;
            status_next = ST_DRIVE_CLOSED;
        end else if (in_light) begin
            cmd_next.ign = 1'b1;
            status_next = ST_DRIVE_IGN;
        end else if (modulating) begin
            cmd_next.open = pulse_open;
            cmd_next.close = pulse_close;
            status_next = ST_MODULATING;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_reg <= '0;
            cmd_status <= ST_IDLE;
        end else begin
            cmd_reg <= cmd_next;
            cmd_status <= status_next;
        end
    end

    assign {damper_open, damper_close, damper_ign} = cmd_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence alarm_raised_s;
        !draft_alarm ##1 draft_alarm;
    endsequence

    selector_open_a: assert property (ctrl_reg.selector_open |=> damper_open && cmd_status == ST_SWITCH_OPEN)
        else $error("selector open did not give open command");
    standby_close_a: assert property (!ctrl_reg.selector_open && !ctrl_reg.manual_force && !draft_alarm &&
        !raise_any && phase == PH_STBY_A |=> damper_close && !damper_open)
        else $error("standby phase did not close damper");
    purge_alarm_a: assert property (purge_open_missed && !draft_alarm |=> draft_alarm && alarm_code == ALM_PURGE)
        else $error("purge deadline alarm missing");
    light_alarm_a: assert property (light_off_position_missed && !purge_open_missed && !draft_alarm
        |=> alarm_code == ALM_LIGHT)
        else $error("light-off deadline alarm missing");
    // Only leaving modulation may cut a pulse short
    mod_pulse_len_a: assert property ($rose(mod_reg == MOD_RAISE) |->
        ((mod_reg == MOD_RAISE)[*8] or (##[0:7] !modulating)))
        else $error("modulation pulse too short");
    post_alarm_a: assert property (post_purge_open_missed && !draft_alarm |=> alarm_code == ALM_POST)
        else $error("post-purge deadline alarm missing");
    alarm_forces_open_a: assert property (draft_alarm && !ctrl_reg.selector_open |=> damper_open && !damper_ign)
        else $error("alarm did not force damper open");
    alarm_holds_a: assert property (draft_alarm && !clear_req |=> draft_alarm)
        else $error("alarm cleared without reset request");
    code_kept_a: assert property (alarm_raised_s ##1 (draft_alarm && !clear_req) |-> $stable(alarm_code))
        else $error("first alarm code overwritten");
    idle_status_a: assert property (cmd_status == ST_IDLE |-> !damper_open && !damper_close && !damper_ign)
        else $error("idle status with command present");
    global_clear_a: assert property (draft_alarm && wr_en && paddr == CLEAR_OFS && pwdata[CLEAR_GLOBAL_BIT]
        && !raise_any |=> !draft_alarm)
        else $error("global clear ignored");
    manual_jog_a: assert property (status_next == ST_MANUAL && ctrl_reg.jog_close && !ctrl_reg.jog_open
        |=> damper_close && !damper_open)
        else $error("manual jog close not followed");

    // A clear that meets a standing deadline is ignored, so the alarm cannot blink off
    raise_wins_a: assert property (raise_any && clear_req |=> draft_alarm)
        else $error("alarm clear overrode a new raise");
    // Phases above the proving test hold no command
    unlisted_idle_a: assert property (!ctrl_reg.selector_open && !ctrl_reg.manual_force && !draft_alarm &&
        !raise_any && phase > PH_VPT_HI |=> cmd_status == ST_IDLE && !damper_open && !damper_close && !damper_ign)
        else $error("unlisted phase gave a command");

endmodule

// ---- core/draft_pkg.sv ----
package draft_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;
    localparam int MOD_PERIOD_MS = 1000;
    localparam int MOD_PULSE_MS = 200;
    localparam int MOD_PERIOD_CYC = MOD_PERIOD_MS * CYC_PER_MS;
    localparam int MOD_PULSE_CYC = MOD_PULSE_MS * CYC_PER_MS;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] SETPT_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] CLEAR_OFS = 8'h0c;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SETPT_RST = 32'h0000_0000;
    localparam int CLEAR_DRAFT_BIT = 0;
    localparam int CLEAR_GLOBAL_BIT = 1;
    localparam int ST_ALARM_CODE_LSB = 8;
    localparam int ST_ALARM_BIT = 10;
    localparam int ST_PROOF_LSB = 11;
    localparam int ST_CMD_LSB = 14;
    localparam int ST_PHASE_LSB = 24;

    // ------------------------------------------------------------------
    // Burner phases
    // ------------------------------------------------------------------
    localparam logic [7:0] PH_LOCK_HI = 8'h02;
    localparam logic [7:0] PH_STBY_A = 8'h0a;
    localparam logic [7:0] PH_STBY_B = 8'h0c;
    localparam logic [7:0] PH_PURGE_LO = 8'h14;
    localparam logic [7:0] PH_PURGE_DL = 8'h1e;
    localparam logic [7:0] PH_PURGE_HI = 8'h22;
    localparam logic [7:0] PH_IGN_LO = 8'h24;
    localparam logic [7:0] PH_IGN_DL = 8'h28;
    localparam logic [7:0] PH_IGN_HI = 8'h36;
    localparam logic [7:0] PH_RUN_A = 8'h3c;
    localparam logic [7:0] PH_RUN_B = 8'h3e;
    localparam logic [7:0] PH_POST_LO = 8'h46;
    localparam logic [7:0] PH_POST_DL = 8'h4a;
    localparam logic [7:0] PH_POST_HI = 8'h4e;
    localparam logic [7:0] PH_VPT_LO = 8'h50;
    localparam logic [7:0] PH_VPT_HI = 8'h53;

    localparam logic [1:0] ALM_NONE = 2'h0;
    localparam logic [1:0] ALM_PURGE = 2'h1;
    localparam logic [1:0] ALM_LIGHT = 2'h2;
    localparam logic [1:0] ALM_POST = 2'h3;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_MANUAL = 7'h01,
        ST_IDLE = 7'h02,
        ST_DRIVE_OPEN = 7'h04,
        ST_SWITCH_OPEN = 7'h08,
        ST_DRIVE_CLOSED = 7'h10,
        ST_DRIVE_IGN = 7'h20,
        ST_MODULATING = 7'h40
    } cmd_status_t;

    typedef enum logic [2:0] {
        MOD_WAIT = 3'h1,
        MOD_RAISE = 3'h2,
        MOD_LOWER = 3'h4
    } mod_state_t;

    // Control register, low bits upward: deadband, polarity, rotation, jogs, force, selector
    typedef struct packed {
        logic selector_open;
        logic manual_force;
        logic jog_open;
        logic jog_close;
        logic rot_ccw;
        logic sp_negative;
        logic [7:0] deadband;
    } ctrl_t;

    typedef struct packed {
        logic open;
        logic close;
        logic ign;
    } damper_cmd_t;

endpackage

// ---- tb/damper_partner.sv ----
`timescale 1ns/100ps
module damper_partner #(
    parameter int TRAVEL = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] phase_req,
    input wire logic proof_en,
    input wire logic damper_open,
    input wire logic damper_close,
    input wire logic damper_ign,
    output logic [7:0] burner_phase,
    output logic open_proven,
    output logic closed_proven,
    output logic ign_proven
);
    logic [2:0] drive_reg;
    logic [2:0] pos_reg;
    int travel_reg;
    wire logic [2:0] cmd = {damper_open, damper_close, damper_ign};

    // ----------------------------------------------------------------
    // Burner controller and actuator
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burner_phase <= 8'h00;
        end else begin
            burner_phase <= phase_req;
        end
    end

    // A switch proves only after a command was held a whole travel; idle holds position
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_reg <= 3'h0;
            pos_reg <= 3'h0;
            travel_reg <= 0;
        end else if (cmd != 3'h0 && cmd != drive_reg) begin
            drive_reg <= cmd;
            pos_reg <= 3'h0;
            travel_reg <= 0;
        end else if (cmd != 3'h0 && travel_reg < TRAVEL) begin
            travel_reg <= travel_reg + 1;
        end else if (cmd != 3'h0) begin
            pos_reg <= cmd;
        end
    end

    // Proof switches can be disabled to stand for a stuck damper
    assign open_proven = proof_en & pos_reg[2];
    assign closed_proven = proof_en & pos_reg[1];
    assign ign_proven = proof_en & pos_reg[0];
endmodule

// ---- tb/draft_damper_sequencer_tb.sv ----
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module draft_damper_sequencer_tb
    import draft_pkg::*;
;
    localparam int MODT = 40;
    localparam int MODP = 10;
    // Pin to output is 3 edges; the rest covers actuator travel and proof sync
    localparam int SETTLE = 16;
    typedef struct packed {
        logic [13:0] ctrl;
        logic [7:0] ph;
        logic [2:0] cmd;
        cmd_status_t st;
    } row_t;
    typedef struct {
        logic [13:0] ctrl;
        logic [31:0] sp;
        logic oil;
        logic [7:0] ph;
        int n_open;
        int n_close;
    } mod_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, phase_req = 8'h00, burner_phase;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, fuel_oil = 1'b0, proof_en = 1'b1;
    logic signed [15:0] draft_level = 16'sh0064;
    logic open_proven, closed_proven, ign_proven, damper_open, damper_close, damper_ign, draft_alarm;
    logic [1:0] alarm_code;
    cmd_status_t cmd_status;
    int n_fail = 0, checks_done = 0, no, nc;
    row_t rows [23] = '{
        '{14'h2000, 8'h0a, 3'h4, ST_SWITCH_OPEN}, '{14'h0000, 8'h00, 3'h4, ST_DRIVE_OPEN},
        '{14'h0000, 8'h01, 3'h4, ST_DRIVE_OPEN}, '{14'h0000, 8'h02, 3'h4, ST_DRIVE_OPEN},
        '{14'h0000, 8'h50, 3'h4, ST_DRIVE_OPEN}, '{14'h0000, 8'h53, 3'h4, ST_DRIVE_OPEN},
        '{14'h0000, 8'h0a, 3'h2, ST_DRIVE_CLOSED}, '{14'h0000, 8'h0c, 3'h2, ST_DRIVE_CLOSED},
        '{14'h0000, 8'h14, 3'h4, ST_DRIVE_OPEN}, '{14'h0000, 8'h23, 3'h0, ST_IDLE},
        '{14'h0000, 8'h24, 3'h1, ST_DRIVE_IGN}, '{14'h0000, 8'h36, 3'h1, ST_DRIVE_IGN},
        '{14'h0000, 8'h37, 3'h0, ST_IDLE}, '{14'h0000, 8'h46, 3'h4, ST_DRIVE_OPEN},
        '{14'h0000, 8'h4e, 3'h4, ST_DRIVE_OPEN}, '{14'h0000, 8'h54, 3'h0, ST_IDLE},
        '{14'h0000, 8'h0d, 3'h0, ST_IDLE}, '{14'h0000, 8'hc8, 3'h0, ST_IDLE},
        '{14'h1800, 8'h0a, 3'h4, ST_MANUAL}, '{14'h1400, 8'h14, 3'h2, ST_MANUAL},
        '{14'h1c00, 8'h0a, 3'h0, ST_MANUAL}, '{14'h1000, 8'h0a, 3'h0, ST_MANUAL},
        '{14'h2400, 8'h0a, 3'h4, ST_SWITCH_OPEN}};
    logic [7:0] alm [3][3] = '{'{PH_PURGE_LO, PH_PURGE_DL, 8'h00},
        '{PH_IGN_LO, PH_IGN_DL, 8'h01}, '{PH_POST_LO, PH_POST_DL, 8'h00}};
    mod_t mods [6] = '{'{14'h0000, 32'h0, 1'b0, PH_RUN_A, 2 * MODP, 0},
        '{14'h0200, 32'h0, 1'b0, PH_RUN_B, 0, 2 * MODP}, '{14'h0100, 32'h0, 1'b0, PH_RUN_A, 0, 2 * MODP},
        '{14'h0300, 32'h0, 1'b0, PH_RUN_A, 2 * MODP, 0}, '{14'h0000, 32'h00c8_0000, 1'b1, PH_RUN_A, 0, 2 * MODP},
        '{14'h0064, 32'h0, 1'b0, PH_RUN_A, 0, 0}};

    draft_damper_sequencer #(.MOD_PERIOD(MODT), .MOD_PULSE(MODP)) draft_damper_sequencer_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .burner_phase(burner_phase), .fuel_oil(fuel_oil), .draft_level(draft_level),
        .open_proven(open_proven), .closed_proven(closed_proven), .ign_proven(ign_proven),
        .damper_open(damper_open), .damper_close(damper_close), .damper_ign(damper_ign),
        .draft_alarm(draft_alarm), .alarm_code(alarm_code), .cmd_status(cmd_status));
    damper_partner #(.TRAVEL(4)) damper_partner_i (
        .pclk(pclk), .presetn(presetn), .phase_req(phase_req), .proof_en(proof_en),
        .damper_open(damper_open), .damper_close(damper_close), .damper_ign(damper_ign),
        .burner_phase(burner_phase), .open_proven(open_proven), .closed_proven(closed_proven),
        .ign_proven(ign_proven));

    initial begin
        forever #10 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Bus and sequencing helpers
    // ----------------------------------------------------------------
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic go(input logic [7:0] ph);
        @(posedge pclk);
        phase_req <= ph;
        repeat (SETTLE) @(posedge pclk);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (11) @(posedge pclk);
        `CHK(cmd_status, ST_IDLE)
        `CHK({damper_open, damper_close, damper_ign, draft_alarm}, 4'h0)
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, CTRL_RST)
        apb(1'b0, SETPT_OFS, 32'h0);
        `CHK(rd, SETPT_RST)
        apb(1'b1, 8'h10, 32'hffff_ffff);
        `CHK(er, 1'b1)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
        apb(1'b1, CTRL_OFS, 32'h0000_3fff);
        apb(1'b0, CTRL_OFS, 32'h0);
        `CHK(rd, 32'h0000_3fff)
        for (int r = 0; r < 23; r++) begin
            apb(1'b1, CTRL_OFS, {18'h0, rows[r].ctrl});
            go(rows[r].ph);
            `CHK({damper_open, damper_close, damper_ign}, rows[r].cmd)
            `CHK(cmd_status, rows[r].st)
        end
        apb(1'b0, STATUS_OFS, 32'h0);
        `CHK({rd[31:24], rd[16:8], rd[6:0]}, {8'h0a, 9'b1_0000_1000, ST_SWITCH_OPEN})
        apb(1'b1, CTRL_OFS, 32'h0);
        // Stuck damper: each deadline raises its code, the first code is kept
        @(posedge pclk);
        proof_en <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            go(alm[i][0]);
            go(alm[i][1] - 8'h01);
            `CHK(draft_alarm, 1'b0)
            go(alm[i][1]);
            `CHK({draft_alarm, alarm_code, damper_open}, {1'b1, 2'(i + 1), 1'b1})
            // A clear while the deadline still stands is ignored
            apb(1'b1, CLEAR_OFS, 32'h3);
            `CHK(draft_alarm, 1'b1)
            go(PH_POST_DL);
            go(PH_STBY_A);
            `CHK({draft_alarm, alarm_code, damper_open}, {1'b1, 2'(i + 1), 1'b1})
            apb(1'b1, CLEAR_OFS, 32'h1 << alm[i][2]);
            go(PH_STBY_A);
            `CHK({draft_alarm, damper_close}, 2'b01)
        end
        @(posedge pclk);
        proof_en <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            go(alm[i][0]);
            go(alm[i][1]);
            `CHK(draft_alarm, 1'b0)
        end
        // Modulation: fresh entry each time so the pulse count covers two whole periods
        for (int m = 0; m < 6; m++) begin
            go(8'h5a);
            apb(1'b1, CTRL_OFS, {18'h0, mods[m].ctrl});
            apb(1'b1, SETPT_OFS, mods[m].sp);
            @(posedge pclk);
            fuel_oil <= mods[m].oil;
            phase_req <= mods[m].ph;
            no = 0;
            nc = 0;
            repeat (2 * MODT) begin
                @(posedge pclk);
                no += (damper_open === 1'b1);
                nc += (damper_close === 1'b1);
            end
            `CHK(cmd_status, ST_MODULATING)
            `CHK(no, mods[m].n_open)
            `CHK(nc, mods[m].n_close)
        end
        // Mid-run reset drops a latched alarm and the command at once
        @(posedge pclk);
        proof_en <= 1'b0;
        go(PH_PURGE_DL);
        `CHK(draft_alarm, 1'b1)
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK({draft_alarm, alarm_code, damper_open, damper_close, damper_ign}, 6'h0)
        `CHK(cmd_status, ST_IDLE)
        phase_req <= 8'h5a;
        presetn <= 1'b1;
        go(8'h5a);
        `CHK({draft_alarm, cmd_status}, {1'b0, ST_IDLE})
        complete_run();
    end
endmodule
